/* design/cpms_cfg.svh */
`ifndef CPMS_CFG_SVH
`define CPMS_CFG_SVH
// Synchroniser depth for pin inputs
`define CPMS_SYNC_STAGES 2
// Readback select encodings
`define CPMS_SEL_RANGE 1'h0
`define CPMS_SEL_READBACK 1'h1
// Width of the data output bus
`define CPMS_DATA_W 12
// Configuration shift word width
`define CPMS_SHIFT_W 16
`endif

/* design/cpms_pkg.sv */
`default_nettype none
package cpms_pkg;
   // Mode of the control pins, chosen by the reset pin level
   typedef enum logic [1:0] {
      CPMS_SERIAL = 2'h0,
      CPMS_PARALLEL = 2'h1
   } cpms_mode_type;
endpackage : cpms_pkg
`default_nettype wire

/* design/cpms_sync.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpms_cfg.svh"
module cpms_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic [4:0] pins,
   cpms_sync_if.src so
);
   import cpms_pkg::*;
   logic [4:0] meta_q, meta_d;
   logic [4:0] stab_q, stab_d;

   // First stage feeds only the second stage
   always_comb begin
      meta_d = pins;
      stab_d = meta_q;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= 5'h00;
         stab_q <= 5'h00;
      end else begin
         meta_q <= meta_d;
         stab_q <= stab_d;
      end
   end

   assign so.reset_pin = stab_q[0];
   assign so.sclk_pin = stab_q[1];
   assign so.serial_in = stab_q[2];
   assign so.select_pin = stab_q[3];
   assign so.drive_en = stab_q[4];
endmodule : cpms_sync
`default_nettype wire

/* design/cpms_sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Synchronised pin levels passed from the synchroniser to the mux logic
interface cpms_sync_if;
   logic reset_pin;
   logic sclk_pin;
   logic serial_in;
   logic select_pin;
   logic drive_en;
   modport src (output reset_pin, sclk_pin, serial_in, select_pin, drive_en);
   modport dst (input reset_pin, sclk_pin, serial_in, select_pin, drive_en);
endinterface : cpms_sync_if
`default_nettype wire

/* design/cpms_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpms_cfg.svh"
module cpms_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic reset_pin,
   input wire logic sclk_pin,
   input wire logic config_serial_in,
   input wire logic config_select,
   input wire logic drive_en_pin,
   input wire logic readback_sel,
   input wire logic range_flag,
   input wire logic readback_bit,
   input wire logic [`CPMS_DATA_W-1:0] sample_data,
   output logic [`CPMS_DATA_W-1:0] data_out,
   output logic data_out_en_n,
   output logic range_flag_or_readback,
   output var cpms_pkg::cpms_mode_type mode,
   output logic standby,
   output logic analog_ctrl,
   output logic regs_default,
   output logic cfg_shift_pulse,
   output logic cfg_bit,
   output logic cfg_enable
);
   import cpms_pkg::*;

   cpms_sync_if sy();

   cpms_sync u_sync (
      .clk(clk),
      .rst(rst),
      .pins({drive_en_pin, config_select, config_serial_in, sclk_pin, reset_pin}),
      .so(sy)
   );

   logic [`CPMS_DATA_W-1:0] data_q, data_d;
   logic oen_q, oen_d;
   logic stat_q, stat_d;
   cpms_mode_type mode_q, mode_d;
   logic stby_q, stby_d;
   logic ana_q, ana_d;
   logic dflt_q, dflt_d;
   logic shift_q, shift_d;
   logic bit_q, bit_d;
   logic cen_q, cen_d;
   logic sclk_prev_q, sclk_prev_d;

   // Pin decode; mode re-evaluated every cycle, no latching of straps
   always_comb begin
      mode_d = sy.reset_pin ? CPMS_PARALLEL : CPMS_SERIAL;
      dflt_d = sy.reset_pin;
      ana_d = sy.reset_pin & sy.select_pin;
      stby_d = sy.reset_pin & sy.serial_in;
      cen_d = ~sy.reset_pin & ~sy.select_pin;
      bit_d = sy.reset_pin ? 1'h0 : sy.serial_in;
      sclk_prev_d = sy.sclk_pin;
      // Rising serial clock edge is ignored in parallel mode
      shift_d = ~sy.reset_pin & sy.sclk_pin & ~sclk_prev_q;
      oen_d = ~sy.drive_en;
      data_d = sample_data;
      stat_d = (readback_sel == `CPMS_SEL_READBACK) ? readback_bit : range_flag;
   end

   // Registered outputs; drivers off until synchronised pin says otherwise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_q <= CPMS_SERIAL;
         dflt_q <= 1'h0;
         ana_q <= 1'h0;
         stby_q <= 1'h0;
         cen_q <= 1'h0;
         bit_q <= 1'h0;
         sclk_prev_q <= 1'h0;
         shift_q <= 1'h0;
         oen_q <= 1'h1;
         data_q <= '0;
         stat_q <= 1'h0;
      end else begin
         mode_q <= mode_d;
         dflt_q <= dflt_d;
         ana_q <= ana_d;
         stby_q <= stby_d;
         cen_q <= cen_d;
         bit_q <= bit_d;
         sclk_prev_q <= sclk_prev_d;
         shift_q <= shift_d;
         oen_q <= oen_d;
         data_q <= data_d;
         stat_q <= stat_d;
      end
   end

   assign data_out = data_q;
   assign data_out_en_n = oen_q;
   assign range_flag_or_readback = stat_q;
   assign mode = mode_q;
   assign standby = stby_q;
   assign analog_ctrl = ana_q;
   assign regs_default = dflt_q;
   assign cfg_shift_pulse = shift_q;
   assign cfg_bit = bit_q;
   assign cfg_enable = cen_q;

   // Checks on the decode, three cycles from pin to output
   sequence s_par_pin;
      reset_pin [*4];
   endsequence

   // Serial clock rise with reset pin low; both share one synchroniser delay
   sequence s_ser_rise;
      !sclk_pin ##1 (sclk_pin && !reset_pin);
   endsequence

   property p_drive;
      @(posedge clk) disable iff (rst) drive_en_pin [*4] |-> !data_out_en_n;
   endproperty
   a_drive: assert property (p_drive) else $error("drivers not enabled");

   property p_stat;
      @(posedge clk) disable iff (rst)
         1'b1 |=> range_flag_or_readback ==
            ($past(readback_sel) ? $past(readback_bit) : $past(range_flag));
   endproperty
   a_stat: assert property (p_stat) else $error("status pin mux wrong");

   property p_dflt;
      @(posedge clk) disable iff (rst) s_par_pin |-> regs_default && mode == CPMS_PARALLEL;
   endproperty
   a_dflt: assert property (p_dflt) else $error("defaults not held");

   property p_ana;
      @(posedge clk) disable iff (rst)
         (reset_pin && config_select) [*4] |-> analog_ctrl;
   endproperty
   a_ana: assert property (p_ana) else $error("analog control missing");

   property p_noshift;
      @(posedge clk) disable iff (rst) s_par_pin |-> !cfg_shift_pulse;
   endproperty
   a_noshift: assert property (p_noshift) else $error("shift in parallel mode");

   property p_bit;
      @(posedge clk) disable iff (rst)
         (!reset_pin && config_serial_in) [*4] |-> cfg_bit && !standby;
   endproperty
   a_bit: assert property (p_bit) else $error("serial data misrouted");

   property p_stby;
      @(posedge clk) disable iff (rst)
         (reset_pin && config_serial_in) [*4] |-> standby && !cfg_bit;
   endproperty
   a_stby: assert property (p_stby) else $error("standby not selected");

   property p_cen;
      @(posedge clk) disable iff (rst)
         (!reset_pin && !config_select) [*4] |-> cfg_enable && !analog_ctrl;
   endproperty
   a_cen: assert property (p_cen) else $error("serial enable wrong");

   property p_follow;
      @(posedge clk) disable iff (rst) $rose(reset_pin) |-> ##3 (mode == CPMS_PARALLEL);
   endproperty
   a_follow: assert property (p_follow) else $error("mode did not follow");

   property p_follow_fall;
      @(posedge clk) disable iff (rst) $fell(reset_pin) |-> ##3 (mode == CPMS_SERIAL);
   endproperty
   a_follow_fall: assert property (p_follow_fall) else $error("mode did not return");

   property p_shift;
      @(posedge clk) disable iff (rst) s_ser_rise |-> ##3 cfg_shift_pulse;
   endproperty
   a_shift: assert property (p_shift) else $error("shift pulse missing");

   property p_drive_off;
      @(posedge clk) disable iff (rst) (!drive_en_pin) [*4] |-> data_out_en_n;
   endproperty
   a_drive_off: assert property (p_drive_off) else $error("drivers not released");

   // Serial mode must drop every parallel-mode function
   property p_ser;
      @(posedge clk) disable iff (rst)
         (!reset_pin) [*4] |-> !regs_default && !analog_ctrl && !standby && mode == CPMS_SERIAL;
   endproperty
   a_ser: assert property (p_ser) else $error("parallel functions left on");

   property p_par_quiet;
      @(posedge clk) disable iff (rst) s_par_pin |-> !cfg_enable && !cfg_bit;
   endproperty
   a_par_quiet: assert property (p_par_quiet) else $error("serial port live");

   property p_rng;
      @(posedge clk) disable iff (rst)
         !readback_sel |=> range_flag_or_readback == $past(range_flag);
   endproperty
   a_rng: assert property (p_rng) else $error("range flag not shown");

   property p_rdb;
      @(posedge clk) disable iff (rst)
         readback_sel |=> range_flag_or_readback == $past(readback_bit);
   endproperty
   a_rdb: assert property (p_rdb) else $error("readback bit not shown");

   // Sample word passes with one register of delay
   property p_data;
      @(posedge clk) disable iff (rst) 1'b1 |=> data_out == $past(sample_data);
   endproperty
   a_data: assert property (p_data) else $error("data word not passed");
endmodule : cpms_top
`default_nettype wire

/* sim/control_pin_mode_select_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module control_pin_mode_select_tb;
   import cpms_pkg::*;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic par = 1'h0;
   logic ana = 1'h0;
   logic [4:0] p;
   logic [4:0] last = 5'h00;
   logic [14:0] cur = 15'h0000;
   logic [14:0] prv = 15'h0000;
   logic [11:0] dout;
   logic en_n, rfr, stby, actl, rdef, pulse, cbit, cen;
   cpms_mode_type mode;
   int num_errors = 0, n_tests = 0, up = 0, stable = 0, n_rise = 0, n_pulse = 0;
   always #5 clk = ~clk;
   cpms_host cpms_host_i (.clk(clk), .rst(rst), .par(par), .ana(ana), .pins(p));
   cpms_top cpms_top_i (.clk(clk), .rst(rst), .reset_pin(p[4]), .sclk_pin(p[1]),
      .config_serial_in(p[2]), .config_select(p[3]), .drive_en_pin(p[0]),
      .readback_sel(cur[14]), .range_flag(cur[13]), .readback_bit(cur[12]),
      .sample_data(cur[11:0]), .data_out(dout), .data_out_en_n(en_n),
      .range_flag_or_readback(rfr), .mode(mode), .standby(stby), .analog_ctrl(actl),
      .regs_default(rdef), .cfg_shift_pulse(pulse), .cfg_bit(cbit), .cfg_enable(cen));
   task automatic chk(input string s, input logic [11:0] e, input logic [11:0] g);
      n_tests++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", s, e, g);
         num_errors++;
      end
   endtask : chk
   task automatic chk1(input string s, input logic e, input logic g);
      chk(s, {11'h000, e}, {11'h000, g});
   endtask : chk1
   task automatic stop_test;
      $display("Checks %0d, errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : stop_test
   // Random same-clock inputs; prv is what the design took at this edge
   always @(posedge clk) begin
      prv <= cur;
      cur <= 15'($urandom);
   end
   // Model compare away from the edge; pin results only once levels settle
   always @(negedge clk) begin
      if (!rst && ++up > 1) begin
         chk("data_out", prv[11:0], dout);
         chk1("range_flag_or_readback", prv[14] ? prv[12] : prv[13], rfr);
         stable = (p[4:2] == last[4:2] && p[0] == last[0]) ? stable + 1 : 0;
         if (p[1] && !last[1] && !p[4]) n_rise++;
         if (pulse === 1'h1) n_pulse++;
         if (stable >= 4) begin
            chk("mode", 12'(p[4] ? CPMS_PARALLEL : CPMS_SERIAL), 12'(mode));
            chk1("regs_default", p[4], rdef);
            chk1("analog_ctrl", p[4] & p[3], actl);
            chk1("standby", p[4] & p[2], stby);
            chk1("cfg_bit", !p[4] & p[2], cbit);
            chk1("cfg_enable", !p[4] & !p[3], cen);
            chk1("data_out_en_n", !p[0], en_n);
         end
      end
      last = p;
   end
   initial begin
      void'($urandom(35));
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      repeat (300) @(posedge clk);
      par <= 1'h1;
      repeat (200) @(posedge clk);
      ana <= 1'h1;
      repeat (300) @(posedge clk);
      par <= 1'h0;
      repeat (300) @(posedge clk);
      // Park in parallel mode so the last shift pulses land before counting
      par <= 1'h1;
      repeat (60) @(posedge clk);
      chk("cfg_shift_pulse", 12'(n_rise), 12'(n_pulse));
      stop_test();
   end
   // Run is about 1200 cycles
   initial begin
      #60000;
      num_errors++;
      stop_test();
   end
endmodule : control_pin_mode_select_tb
`default_nettype wire

/* sim/cpms_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Host pin driver: {reset, select, data, sclk, drive}
module cpms_host (
   input wire logic clk,
   input wire logic rst,
   input wire logic par,
   input wire logic ana,
   output logic [4:0] pins
);
   logic [3:0] cnt_q;
   logic init_q;
   // Levels move every 16 cycles, sclk every 8, so the 3-cycle pin-to-output path sees all
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 4'h0;
         init_q <= 1'h1;
         pins <= 5'h00;
      end else begin
         cnt_q <= cnt_q + 4'h1;
         if (cnt_q == 4'h0) begin
            init_q <= 1'h0;
            // First window is a long high pulse, so serial use starts from defaults
            pins[4] <= par | init_q;
            pins[3] <= ((par | init_q) && !ana) ? 1'h1 : 1'($urandom);
            pins[2] <= 1'($urandom);
            pins[0] <= 1'($urandom);
         end
         // Old reset level used, so sclk never rises as serial mode starts
         pins[1] <= pins[4] ? 1'h0 : cnt_q[3];
      end
   end
endmodule : cpms_host
`default_nettype wire
